// *** rhpi_pkg.sv ***
`default_nettype none
package rhpi_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_HOLD = 8'h08;
  localparam logic [7:0] ADDR_AUTO = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_IDLO = 8'h14;
  localparam logic [7:0] ADDR_IDHI = 8'h18;
  localparam logic [2:0] DATA_WIN = 3'h1;
  // ----------------------------------------
  // field layout and limits
  // ----------------------------------------
  localparam int CTRL_ANT_BIT = 3;
  localparam int CTRL_START_BIT = 8;
  localparam int PARAM_REV_BIT = 8;
  localparam int AUTO_LEN_LSB = 16;
  localparam int IMG_BYTES = 32;
  localparam logic [4:0] LEN_MIN = 5'h01;
  localparam logic [4:0] LEN_MAX = 5'h1d;
  localparam logic [7:0] BSIZE_4 = 8'h04;
  localparam logic [7:0] BSIZE_8 = 8'h08;
  localparam logic [7:0] BSIZE_16 = 8'h10;
  localparam logic [7:0] BSIZE_32 = 8'h20;
  // ----------------------------------------
  // operating modes (command values)
  // ----------------------------------------
  localparam logic [2:0] MODE_UID = 3'h0;
  localparam logic [2:0] MODE_AUTO_RD = 3'h1;
  localparam logic [2:0] MODE_AUTO_WR = 3'h2;
  localparam logic [2:0] MODE_RD = 3'h3;
  localparam logic [2:0] MODE_WR = 3'h4;
  // ----------------------------------------
  // reset values and error codes
  // ----------------------------------------
  localparam logic [7:0] BSIZE_RST = 8'h04;
  localparam logic [15:0] HOLD_RST = 16'h01f4;
  localparam logic [15:0] AUTO_ADDR_RST = 16'h0000;
  localparam logic [4:0] AUTO_LEN_RST = 5'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_TAG = 8'h01;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] PULSE_MS = 10'h064;
  localparam logic [9:0] ERR_SHOW_MS = 10'h3e8;
  localparam logic [9:0] FAST_HALF_MS = 10'h032;
  localparam logic [9:0] SLOW_HALF_MS = 10'h1f4;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} rhpi_state_t;
endpackage
`default_nettype wire

// *** rhpi_led.sv ***
`timescale 1ns/1ps
`default_nettype none
module rhpi_led
  import rhpi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic msTick,
  input wire logic tagOn,
  input wire logic okPulse,
  input wire logic errPulse,
  input wire logic antOff,
  input wire logic fault,
  output logic ledGreen,
  output logic ledYellow
);
  logic [9:0] pulseLeft_r;
  logic [9:0] errLeft_r;
  logic [9:0] fastCnt_r;
  logic [9:0] slowCnt_r;
  logic fastPh_r;
  logic slowPh_r;

  // ----------------------------------------
  // blink phases
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      fastCnt_r <= 10'h000;
      fastPh_r <= 1'b0;
    end
    else if (msTick)
    begin
      if (fastCnt_r == FAST_HALF_MS - 10'h001)
      begin
        fastCnt_r <= 10'h000;
        fastPh_r <= ~fastPh_r;
      end
      else
        fastCnt_r <= fastCnt_r + 10'h001;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      slowCnt_r <= 10'h000;
      slowPh_r <= 1'b0;
    end
    else if (msTick)
    begin
      if (slowCnt_r == SLOW_HALF_MS - 10'h001)
      begin
        slowCnt_r <= 10'h000;
        slowPh_r <= ~slowPh_r;
      end
      else
        slowCnt_r <= slowCnt_r + 10'h001;
    end

  // ----------------------------------------
  // event stretchers
  // ----------------------------------------
  // a new event restarts its display even mid-flash
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      pulseLeft_r <= 10'h000;
    else if (okPulse)
      pulseLeft_r <= PULSE_MS;
    else if (msTick && pulseLeft_r != 10'h000)
      pulseLeft_r <= pulseLeft_r - 10'h001;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      errLeft_r <= 10'h000;
    else if (errPulse)
      errLeft_r <= ERR_SHOW_MS;
    else if (msTick && errLeft_r != 10'h000)
      errLeft_r <= errLeft_r - 10'h001;

  // ----------------------------------------
  // indicator drive
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ledGreen <= 1'b0;
      ledYellow <= 1'b0;
    end
    else if (fault)
    begin
      ledGreen <= fastPh_r;
      ledYellow <= ~fastPh_r;
    end
    else
    begin
      ledGreen <= antOff ? slowPh_r : 1'b1;
      if (errLeft_r != 10'h000)
        ledYellow <= fastPh_r;
      else if (pulseLeft_r != 10'h000)
        ledYellow <= 1'b1;
      else
        ledYellow <= tagOn;
    end
endmodule
`default_nettype wire

// *** rhpi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - tag data read and written is presented to the master as process data
// - talks to passive iso 15693 tags powered by own antenna field
// - parameters accepted from master at any time, operation keeps running
// - block size accepts only 4, 8, 16 or 32 bytes
// - block size used internally only; tag memory addressed per byte
// - byte order parameter selects normal or reversed order within block
// - normal shows block bytes 3,2,1,0; reversed shows 0,1,2,3
// - serial id, tag present and auto data held for the hold time
// - held id and presence stay after tag leaves until the hold time counted from arrival or from the last completed read runs out
// - hold time has no effect in on-demand read and write modes
// - start address in bytes gives first location for automatic modes
// - automatic modes access configured byte count with no master command
// - tag led pulses on success, flashes fast on failure
// - tag led steady with valid tag, dark otherwise
// - both leds alternate on link error or device fault
// - automatic length counted in bytes, 1 to 29
// - tag present reads 0 without tag, 1 with tag
module rhpi_top
  import rhpi_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tagInField,
  input wire logic tagValid,
  input wire logic [63:0] tag_serial_id,
  output logic tagReq,
  output logic tagWrite,
  output logic [15:0] tagAddr,
  output logic [7:0] tagWrData,
  input wire logic [7:0] tagRdData,
  input wire logic tagDone,
  input wire logic tagFail,
  output logic antennaOn,
  input wire logic linkError,
  input wire logic devFault,
  output logic ledGreen,
  output logic ledYellow
);
  logic [2:0] mode_r;
  logic antOff_r;
  logic start_r;
  logic startPrev_r;
  logic [7:0] bsize_r;
  logic rev_r;
  logic [15:0] holdMs_r;
  logic [15:0] autoAddr_r;
  logic [4:0] autoLen_r;
  logic ack_r;
  logic end_r;
  logic [7:0] err_r;
  logic present_r;
  logic [63:0] uid_r;
  logic dataValid_r;
  logic [15:0] holdLeft_r;
  logic [31:0] msCnt_r;
  logic msTick;
  logic [7:0] dataMem [0:IMG_BYTES-1];
  rhpi_state_t state_r;
  logic [4:0] cnt_r;
  logic [4:0] seqLen_r;
  logic [15:0] seqAddr_r;
  logic okPulse;
  logic errPulse;
  logic apbWr;
  logic dataHit;
  logic [31:0] rdData;
  logic rdErr;
  logic [31:0] laneData;
  logic tagOk;
  logic onDemand;
  logic newTag;
  logic autoTrig;
  logic cmdTrig;
  logic seqStore;
  logic seqLast;
  logic [4:0] cntInc;

  // in normal order the byte position inside a block is mirrored by xor with block mask; reversed order passes it unchanged
  function automatic logic [15:0] mapAddr(input logic [15:0] a);
    mapAddr = rev_r ? a : (a ^ {8'h00, bsize_r - 8'h01});
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign apbWr = psel & penable & pwrite;
  assign dataHit = (paddr[7:5] == DATA_WIN) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & rdErr;

  genvar l;
  generate
    for (l = 0; l < 4; l++)
    begin : g_lane
      logic [4:0] idx;
      assign idx = {paddr[4:2], 2'(l)};
      // auto read pads past the length and blanks expired data
      assign laneData[8*l +: 8] = (mode_r == MODE_AUTO_RD && (!dataValid_r || idx >= seqLen_r)) ?
                                  8'h00 : dataMem[idx];
    end
  endgenerate

  always_comb
  begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    case (paddr)
      ADDR_CTRL: rdData = {23'h000000, start_r, 4'h0, antOff_r, mode_r};
      ADDR_PARAM: rdData = {23'h000000, rev_r, bsize_r};
      ADDR_HOLD: rdData = {16'h0000, holdMs_r};
      ADDR_AUTO: rdData = {11'h000, autoLen_r, autoAddr_r};
      ADDR_STAT: rdData = {16'h0000, err_r, 4'h0, antOff_r, present_r, end_r, ack_r};
      ADDR_IDLO: rdData = uid_r[31:0];
      ADDR_IDHI: rdData = uid_r[63:32];
      default:
        if (dataHit)
          rdData = laneData;
        else
          rdErr = 1'b1;
    endcase
  end

  // read data is captured in the setup cycle so the access phase never waits
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdData;

  // ----------------------------------------
  // parameter registers
  // ----------------------------------------
  // written any time; a running sequence keeps its latched start address, length and direction
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      mode_r <= MODE_UID;
      antOff_r <= 1'b0;
      start_r <= 1'b0;
      bsize_r <= BSIZE_RST;
      rev_r <= 1'b0;
      holdMs_r <= HOLD_RST;
      autoAddr_r <= AUTO_ADDR_RST;
      autoLen_r <= AUTO_LEN_RST;
    end
    else if (apbWr)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          mode_r <= pwdata[2:0];
          antOff_r <= pwdata[CTRL_ANT_BIT];
          start_r <= pwdata[CTRL_START_BIT];
        end
        ADDR_PARAM:
        begin
          rev_r <= pwdata[PARAM_REV_BIT];
          if (pwdata[7:0] == BSIZE_4 || pwdata[7:0] == BSIZE_8 ||
              pwdata[7:0] == BSIZE_16 || pwdata[7:0] == BSIZE_32)
            bsize_r <= pwdata[7:0];
        end
        ADDR_HOLD: holdMs_r <= pwdata[15:0];
        ADDR_AUTO:
        begin
          autoAddr_r <= pwdata[15:0];
          if (pwdata[AUTO_LEN_LSB +: 5] >= LEN_MIN && pwdata[AUTO_LEN_LSB +: 5] <= LEN_MAX)
            autoLen_r <= pwdata[AUTO_LEN_LSB +: 5];
        end
        default: ;
      endcase
    end

  assign antennaOn = ~antOff_r;

  // ----------------------------------------
  // tag presence and hold
  // ----------------------------------------
  assign tagOk = tagInField & tagValid & ~antOff_r;
  assign onDemand = (mode_r == MODE_RD) || (mode_r == MODE_WR);
  assign newTag = tagOk && (!present_r || tag_serial_id != uid_r);

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      msCnt_r <= 32'h0000_0000;
    else if (msTick)
      msCnt_r <= 32'h0000_0000;
    else
      msCnt_r <= msCnt_r + 32'h0000_0001;
  assign msTick = (msCnt_r == 32'(MS_CYCLES - 1));

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      holdLeft_r <= 16'h0000;
    else if (newTag || (seqStore && seqLast))
      holdLeft_r <= holdMs_r;
    else if (msTick && holdLeft_r != 16'h0000)
      holdLeft_r <= holdLeft_r - 16'h0001;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      present_r <= 1'b0;
      uid_r <= 64'h0;
    end
    else if (newTag)
    begin
      present_r <= 1'b1;
      uid_r <= tag_serial_id;
    end
    else if (!tagOk && (onDemand || holdLeft_r == 16'h0000))
    begin
      present_r <= 1'b0;
      uid_r <= 64'h0;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      dataValid_r <= 1'b0;
    else if (seqStore && seqLast)
      dataValid_r <= 1'b1;
    else if (!tagOk && holdLeft_r == 16'h0000)
      dataValid_r <= 1'b0;

  // ----------------------------------------
  // tag access sequencer
  // ----------------------------------------
  assign autoTrig = newTag && (mode_r == MODE_AUTO_RD || mode_r == MODE_AUTO_WR);
  assign cmdTrig = start_r && !startPrev_r && onDemand;
  assign cntInc = cnt_r + 5'h01;
  assign seqLast = (cntInc == seqLen_r);
  assign seqStore = (state_r == ST_BUSY) && tagOk && tagDone && !tagFail && !tagWrite;
  assign tagReq = (state_r == ST_BUSY);
  assign okPulse = (state_r == ST_BUSY) && tagOk && tagDone && !tagFail && seqLast;
  assign errPulse = (state_r == ST_BUSY) && (tagFail || !tagOk);

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      startPrev_r <= 1'b0;
    else
      startPrev_r <= start_r;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      seqLen_r <= AUTO_LEN_RST;
      seqAddr_r <= 16'h0000;
      tagWrite <= 1'b0;
      tagAddr <= 16'h0000;
      tagWrData <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (autoTrig || cmdTrig)
          begin
            state_r <= ST_BUSY;
            cnt_r <= 5'h00;
            seqLen_r <= autoLen_r;
            seqAddr_r <= autoAddr_r;
            tagWrite <= (mode_r == MODE_AUTO_WR) || (mode_r == MODE_WR);
            tagAddr <= mapAddr(autoAddr_r);
            tagWrData <= dataMem[0];
          end
        ST_BUSY:
          if (tagFail || !tagOk)
            state_r <= ST_DONE;
          else if (tagDone)
          begin
            if (seqLast)
              state_r <= ST_DONE;
            else
            begin
              cnt_r <= cntInc;
              tagAddr <= mapAddr(seqAddr_r + {11'h000, cntInc});
              tagWrData <= dataMem[cntInc];
            end
          end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end

  // a tag result wins over any bus write to the data window in the same cycle
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
        dataMem[i] <= 8'h00;
    end
    else if (seqStore)
      dataMem[cnt_r] <= tagRdData;
    else if (apbWr && dataHit)
    begin
      for (int b = 0; b < 4; b++)
        dataMem[{paddr[4:2], 2'(b)}] <= pwdata[8*b +: 8];
    end

  // ----------------------------------------
  // command status
  // ----------------------------------------
  // completion set wins over the clear from a dropped start
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ack_r <= 1'b0;
      end_r <= 1'b0;
      err_r <= ERR_NONE;
    end
    else
    begin
      if (cmdTrig)
        ack_r <= 1'b1;
      else if (!start_r)
        ack_r <= 1'b0;
      if (okPulse || errPulse)
        end_r <= 1'b1;
      else if (autoTrig || cmdTrig || (onDemand && !start_r))
        end_r <= 1'b0;
      if (errPulse)
        err_r <= ERR_TAG;
      else if (autoTrig || cmdTrig)
        err_r <= ERR_NONE;
    end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  rhpi_led u_led (
    .mclk(mclk),
    .rst(rst),
    .msTick(msTick),
    .tagOn(tagOk),
    .okPulse(okPulse),
    .errPulse(errPulse),
    .antOff(antOff_r),
    .fault(linkError | devFault),
    .ledGreen(ledGreen),
    .ledYellow(ledYellow)
  );
endmodule
`default_nettype wire

// *** rhpi_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rhpi_properties
  import rhpi_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tagReq,
  input wire logic [15:0] tagAddr,
  input wire logic tagDone,
  input wire logic tagFail,
  input wire logic antennaOn,
  input wire logic linkError,
  input wire logic devFault,
  input wire logic ledGreen,
  input wire logic ledYellow
);
  // ----------------------------------------
  // bus, tag link and indicator checks
  // ----------------------------------------
  logic badAddr;
  assign badAddr = (paddr[1:0] != 2'h0) || (paddr == 8'h1c) || (paddr > 8'h3c);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == ADDR_CTRL;
  endsequence
  // three cycles give the led logic time to pick up the fault
  sequence s_fault_held;
    (linkError || devFault) [*3];
  endsequence
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (psel && penable && badAddr |-> pslverr)
    else $error("no slave error on unmapped address");
  a_read_zero: assert property (s_rd_setup ##1 (penable && badAddr) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read setup");
  a_fail_abort: assert property (tagReq && tagFail |=> !tagReq)
    else $error("request kept after tag failure");
  a_addr_hold: assert property (tagReq && !tagDone |=> !tagReq || $stable(tagAddr))
    else $error("tag address moved without completion");
  a_antenna_follow: assert property (s_ctrl_wr |=> antennaOn == !$past(pwdata[CTRL_ANT_BIT]))
    else $error("antenna output does not follow control write");
  a_fault_alt: assert property (s_fault_held |-> ledGreen != ledYellow)
    else $error("indicators not alternating on fault");
endmodule
bind rhpi_top rhpi_properties #(.MS_CYCLES(MS_CYCLES)) rhpi_properties_i (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tagReq(tagReq), .tagAddr(tagAddr), .tagDone(tagDone),
  .tagFail(tagFail), .antennaOn(antennaOn), .linkError(linkError), .devFault(devFault), .ledGreen(ledGreen),
  .ledYellow(ledYellow));
`default_nettype wire

// *** rhpi_tag_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rhpi_tag_model
  import rhpi_pkg::*;
#(
  parameter int LAT = 3
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tagReq,
  input wire logic tagWrite,
  input wire logic [15:0] tagAddr,
  input wire logic [7:0] tagWrData,
  input wire logic slow,
  input wire logic failNext,
  output logic tagDone,
  output logic tagFail,
  output logic [7:0] tagRdData
);
  // ----------------------------------------
  // passive tag memory, one byte per access
  // ----------------------------------------
  logic [7:0] mem [256];
  logic [7:0] cnt;
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) * 8'h03 + 8'h11;
  always @(posedge mclk)
    if (tagDone && tagWrite)
      mem[tagAddr[7:0]] <= tagWrData;
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tagDone <= 1'b0;
      tagFail <= 1'b0;
      tagRdData <= 8'h00;
      cnt <= 8'h00;
    end
    else
    begin
      tagDone <= 1'b0;
      tagFail <= 1'b0;
      // data line wanders between answers so a stale byte never looks valid
      tagRdData <= ~tagRdData;
      cnt <= cnt + 8'h01;
      if (!tagReq || tagDone || tagFail)
        cnt <= 8'h00;
      else if (cnt == (slow ? 8'h14 : 8'(LAT)))
      begin
        cnt <= 8'h00;
        tagFail <= failNext;
        tagDone <= !failNext;
        tagRdData <= mem[tagAddr[7:0]];
      end
    end
  end
endmodule
`default_nettype wire

// *** rfid_head_param_indicator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfid_head_param_indicator_tb_top
  import rhpi_pkg::*;
;
  // ----------------------------------------
  // stimulus, queued expectations, monitor
  // ----------------------------------------
  logic mclk, pready, pslverr, tagReq, tagWrite, tagDone, tagFail, antennaOn, ledGreen, ledYellow;
  logic rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tagInField = 1'b0, tagValid = 1'b0;
  logic linkError = 1'b0, devFault = 1'b0, slow = 1'b0, failNext = 1'b0;
  logic [7:0] paddr = 8'h00, tagWrData, tagRdData;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [63:0] serialId = 64'h0;
  logic [15:0] tagAddr;
  logic [32:0] monExp, monMsk, expQ[$], mskQ[$];
  string nmQ[$];
  int mismatches = 0, tests_run = 0, cycles = 0, seed = 73179;
  logic [7:0] sizes [4] = '{BSIZE_8, BSIZE_16, BSIZE_32, BSIZE_4};
  logic [4:0] lens [4] = '{5'h00, LEN_MAX, 5'h1e, LEN_MIN};
  logic [7:0] bss [3] = '{BSIZE_4, BSIZE_8, BSIZE_4};
  logic revs [3] = '{1'b1, 1'b1, 1'b0};
  int starts [3] = '{5, 2, 9};
  rhpi_top #(.MS_CYCLES(10)) rhpi_top_i (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tagInField(tagInField), .tagValid(tagValid),
    .tag_serial_id(serialId), .tagReq(tagReq), .tagWrite(tagWrite), .tagAddr(tagAddr), .tagWrData(tagWrData),
    .tagRdData(tagRdData), .tagDone(tagDone), .tagFail(tagFail), .antennaOn(antennaOn), .linkError(linkError),
    .devFault(devFault), .ledGreen(ledGreen), .ledYellow(ledYellow));
  rhpi_tag_model rhpi_tag_model_i (.mclk(mclk), .rst(rst), .tagReq(tagReq), .tagWrite(tagWrite),
    .tagAddr(tagAddr), .tagWrData(tagWrData), .slow(slow), .failNext(failNext), .tagDone(tagDone),
    .tagFail(tagFail), .tagRdData(tagRdData));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      summarize();
    end
  end
  // one note is taken off per completed access, in bus order
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1 && expQ.size() > 0)
    begin
      monExp = expQ.pop_front();
      monMsk = mskQ.pop_front();
      chk(nmQ.pop_front(), {pslverr, prdata} & monMsk, monExp & monMsk);
    end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m, input string nm);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    expQ.push_back(e);
    mskQ.push_back(m);
    nmQ.push_back(nm);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h1_0000_0000, "write error");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m}, nm);
  endtask
  task automatic arrive();
    serialId <= {$random(seed), $random(seed)};
    tagInField <= 1'b1;
    tagValid <= 1'b1;
  endtask
  task automatic leave();
    tagInField <= 1'b0;
    tagValid <= 1'b0;
    repeat (120) @(posedge mclk);
  endtask
  task automatic waitSeq();
    int i;
    for (i = 0; i < 400 && tagReq !== 1'b1; i++) @(posedge mclk);
    for (i = 0; i < 400 && tagReq !== 1'b0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic toggles(input logic yel, input int n, output int cnt);
    logic prev;
    cnt = 0;
    prev = yel ? ledYellow : ledGreen;
    repeat (n)
    begin
      @(posedge mclk);
      if ((yel ? ledYellow : ledGreen) !== prev)
        cnt++;
      prev = yel ? ledYellow : ledGreen;
    end
  endtask
  function automatic logic [7:0] tagByte(input logic [15:0] a);
    return a[7:0] * 8'h03 + 8'h11;
  endfunction
  initial
  begin
    int k, j, cnt, st;
    logic [7:0] bs, cur;
    logic [4:0] len;
    logic [31:0] w;
    logic [15:0] a;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    wr(ADDR_STAT, 32'hffffffff);
    rd(ADDR_STAT, 32'h0, 32'hff0f, "status after reset");
    rd(ADDR_HOLD, {16'h0, HOLD_RST}, 32'hffff, "hold");
    apb(1'b1, 8'h1c, 32'h1234, 33'h1_0000_0000, 33'h1_0000_0000, "unmapped write");
    apb(1'b0, 8'h02, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff, "unaligned read");
    chk("green steady", {32'h0, ledGreen}, 33'h1);
    cur = BSIZE_RST;
    for (k = 0; k < 8; k++)
    begin
      bs = k[0] ? sizes[k >> 1] : (8'($random(seed)) | 8'h01);
      cur = k[0] ? bs : cur;
      wr(ADDR_PARAM, {24'h0, bs});
      rd(ADDR_PARAM, {24'h0, cur}, 32'h1ff, "block size");
    end
    len = AUTO_LEN_RST;
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_AUTO, {11'h0, lens[k], 16'h0007});
      if (lens[k] >= LEN_MIN && lens[k] <= LEN_MAX)
        len = lens[k];
      rd(ADDR_AUTO, {11'h0, len, 16'h0007}, 32'h1fffff, "length");
    end
    wr(ADDR_HOLD, 32'h5);
    arrive();
    repeat (5) @(posedge mclk);
    tagInField <= 1'b0;
    tagValid <= 1'b0;
    rd(ADDR_IDLO, serialId[31:0], 32'hffffffff, "id low held");
    rd(ADDR_IDHI, serialId[63:32], 32'hffffffff, "id high held");
    rd(ADDR_STAT, 32'h4, 32'h4, "present held");
    repeat (120) @(posedge mclk);
    rd(ADDR_STAT, 32'h0, 32'h4, "present cleared");
    rd(ADDR_IDLO, 32'h0, 32'hffffffff, "id cleared");
    tagInField <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("yellow invalid tag", {32'h0, ledYellow}, 33'h0);
    tagValid <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("yellow valid tag", {32'h0, ledYellow}, 33'h1);
    leave();
    wr(ADDR_CTRL, 32'(MODE_AUTO_RD));
    for (k = 0; k < 3; k++)
    begin
      wr(ADDR_PARAM, {23'h0, revs[k], bss[k]});
      wr(ADDR_AUTO, {11'h0, 5'h03, 16'(starts[k])});
      arrive();
      waitSeq();
      w = 32'h0;
      for (j = 0; j < 3; j++)
      begin
        a = 16'(starts[k] + j);
        if (!revs[k])
          a = a ^ 16'(bss[k] - 8'h01);
        w[8*j +: 8] = tagByte(a);
      end
      rd(ADDR_STAT, 32'h2, 32'h2, "cmd end");
      rd(8'h20, w, 32'hffffffff, "auto data");
      leave();
    end
    wr(8'h20, 32'hc3a59617);
    for (k = 0; k < 2; k++)
    begin
      st = 40 + 10 * k;
      wr(ADDR_AUTO, {11'h0, 5'h02, 16'(st)});
      if (k == 0)
        wr(ADDR_CTRL, 32'(MODE_AUTO_WR));
      arrive();
      if (k == 1)
        wr(ADDR_CTRL, 32'h100 | 32'(MODE_WR));
      waitSeq();
      chk("tag byte 0", {25'h0, rhpi_tag_model_i.mem[st ^ 3]}, 33'h17);
      chk("tag byte 1", {25'h0, rhpi_tag_model_i.mem[(st + 1) ^ 3]}, 33'h96);
      if (k == 0)
        leave();
    end
    rd(ADDR_STAT, 32'h7, 32'h7, "ack end present");
    tagInField <= 1'b0;
    tagValid <= 1'b0;
    rd(ADDR_STAT, 32'h0, 32'h4, "present on demand");
    wr(ADDR_AUTO, {11'h0, 5'h02, 16'h0003});
    wr(ADDR_CTRL, 32'(MODE_RD));
    arrive();
    slow <= 1'b1;
    failNext <= 1'b1;
    wr(ADDR_CTRL, 32'h100 | 32'(MODE_RD));
    waitSeq();
    rd(ADDR_STAT, {16'h0, ERR_TAG, 8'h0}, 32'hff00, "error code");
    toggles(1'b1, 2000, cnt);
    chk("fast flash", {32'h0, cnt >= 3}, 33'h1);
    failNext <= 1'b0;
    wr(ADDR_CTRL, 32'(MODE_RD));
    wr(ADDR_CTRL, 32'h100 | 32'(MODE_RD));
    waitSeq();
    rd(8'h20, {16'h0, tagByte(16'h7), tagByte(16'h0)}, 32'hffff, "slow read");
    leave();
    wr(ADDR_CTRL, 32'h8);
    // let the green drive settle onto the slow phase before counting
    repeat (2) @(posedge mclk);
    toggles(1'b0, 12000, cnt);
    chk("slow flash", {32'h0, cnt >= 2 && cnt <= 3}, 33'h1);
    wr(ADDR_CTRL, 32'h0);
    linkError <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("alternate", {32'h0, ledGreen ^ ledYellow}, 33'h1);
    linkError <= 1'b0;
    devFault <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("alternate fault", {32'h0, ledGreen ^ ledYellow}, 33'h1);
    devFault <= 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
